/* shared/rap_pkg.sv */
package rap_pkg;
	// core clock and link timing
	localparam int CLK_MHZ = 125;
	localparam int SCL_QTR_NS = 625;
	localparam logic [9:0] SCL_QTR_CYC = 10'((SCL_QTR_NS * CLK_MHZ + 999) / 1000);
	// slave address, upper four bits fixed
	localparam logic [3:0] DEV_ADDR_HI = 4'h4;
	// status byte field positions
	localparam int ST_ROUTE_LO = 0;
	localparam int ST_ROUTE_HI = 1;
	localparam int ST_FAULT = 2;
	localparam int ST_THERM = 3;
	localparam int ST_SUPPLY = 4;
	localparam int ST_MISM = 5;
	localparam int ST_INT_DIS = 6;
	localparam int ST_CLEAR = 7;
	// values after reset
	localparam logic [1:0] ROUTE_RST = 2'h3;
	localparam logic INT_DIS_RST = 1'h1;
	// read sequence: status, power one, power two
	localparam logic [1:0] RD_LAST_IDX = 2'h2;
	// linearization store, 32 kbyte
	localparam int LIN_DEPTH = 32768;
	localparam int LIN_AW = 15;
	// host command port offsets
	localparam logic [7:0] HOST_CMD = 8'h00;
	localparam logic [7:0] HOST_ADDR = 8'h04;
	localparam logic [7:0] HOST_STAT = 8'h08;
	localparam logic [7:0] HOST_RXD = 8'h0c;
	localparam logic [7:0] HOST_EVT = 8'h10;
	localparam logic [7:0] HOST_MASK = 8'h14;
	localparam int CMD_READ = 8;

	typedef enum logic [2:0] {
		DS_IDLE  = 3'b000,
		DS_ADDR  = 3'b001,
		DS_AACK  = 3'b010,
		DS_WDATA = 3'b011,
		DS_WACK  = 3'b100,
		DS_RDATA = 3'b101,
		DS_RACK  = 3'b110
	} rap_dev_state_t;

	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_START = 2'b01,
		HS_BIT   = 2'b10,
		HS_STOP  = 2'b11
	} rap_host_state_t;
endpackage

/* shared/rap_link_if.sv */
`timescale 1ns/1ps
interface rap_link_if;
	logic scl;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic sda;
	logic devIntOut;
	logic devIntOe;
	logic statusIntN;

	// open-drain wires with pull-up
	assign sda = (hostSdaOe ? hostSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);
	assign statusIntN = devIntOe ? devIntOut : 1'b1;

	modport host (output scl, hostSdaOut, hostSdaOe, input sda, statusIntN);
	modport dev (input scl, sda, output devSdaOut, devSdaOe, devIntOut, devIntOe);
endinterface

/* rtl/rap_host.sv */
`timescale 1ns/1ps
module rap_host
	import rap_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// link
	rap_link_if.host         link,
	// command port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wrData,
	input  wire logic        wrStb,
	input  wire logic        rdStb,
	output logic      [31:0] rdData,
	// interrupt
	output logic             irq
);
	rap_host_state_t state_q;
	logic [9:0]  div_q;
	logic        tick;
	logic [1:0]  phase_q;
	logic [3:0]  bitCnt_q;
	logic [1:0]  byteIdx_q;
	logic        isRead_q;
	logic [7:0]  txData_q;
	logic [2:0]  strap_q;
	logic [7:0]  rxShift_q;
	logic [23:0] rx_q;
	logic        nack_q;
	logic        scl_q;
	logic        sdaOe_q;
	logic        done;
	logic [1:0]  sdaSync_q;
	logic [1:0]  intSync_q;
	logic        intPrev_q;
	logic [1:0]  evt_q;
	logic [1:0]  mask_q;
	logic [7:0]  txByte;
	logic        sending;
	logic        lastByte;
	logic        rdEvt;

	assign link.scl = scl_q;
	assign link.hostSdaOut = 1'b0;
	assign link.hostSdaOe = sdaOe_q;
	assign tick = (div_q == SCL_QTR_CYC - 10'h001);
	assign txByte = (byteIdx_q == 2'h0) ? {DEV_ADDR_HI, strap_q, isRead_q} : txData_q;
	assign sending = (byteIdx_q == 2'h0) | ~isRead_q;
	assign lastByte = isRead_q ? (byteIdx_q == 2'h3) : (byteIdx_q == 2'h1);
	assign done = (state_q == HS_STOP) & tick & (phase_q == 2'h3);
	assign irq = |(evt_q & mask_q);
	assign rdEvt = rdStb & (addr == HOST_EVT);

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			sdaSync_q <= 2'h3;
			intSync_q <= 2'h3;
			intPrev_q <= 1'b1;
		end
		else
		begin
			sdaSync_q <= {sdaSync_q[0], link.sda};
			intSync_q <= {intSync_q[0], link.statusIntN};
			intPrev_q <= intSync_q[1];
		end

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			div_q <= 10'h000;
		else
			div_q <= tick ? 10'h000 : div_q + 10'h001;

	// link sequencer, four quarter ticks per bit
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			state_q <= HS_IDLE;
			phase_q <= 2'h0;
			bitCnt_q <= 4'h0;
			byteIdx_q <= 2'h0;
			isRead_q <= 1'b0;
			txData_q <= 8'h00;
			rxShift_q <= 8'h00;
			rx_q <= 24'h000000;
			nack_q <= 1'b0;
			scl_q <= 1'b1;
			sdaOe_q <= 1'b0;
		end
		else if (state_q == HS_IDLE)
		begin
			if (wrStb && addr == HOST_CMD)
			begin
				state_q <= HS_START;
				phase_q <= 2'h0;
				isRead_q <= wrData[CMD_READ];
				txData_q <= wrData[7:0];
				nack_q <= 1'b0;
				byteIdx_q <= 2'h0;
				bitCnt_q <= 4'h0;
			end
		end
		else if (tick)
		begin
			phase_q <= phase_q + 2'h1;
			case (state_q)
				HS_START:
					if (phase_q == 2'h0)
						sdaOe_q <= 1'b1;
					else if (phase_q == 2'h1)
					begin
						scl_q <= 1'b0;
						state_q <= HS_BIT;
						phase_q <= 2'h0;
					end
				HS_BIT:
					case (phase_q)
						2'h0:
							if (bitCnt_q < 4'h8)
								sdaOe_q <= sending & ~txByte[3'(4'h7 - bitCnt_q)];
							else
								sdaOe_q <= ~sending & ~lastByte;
						2'h1:
							scl_q <= 1'b1;
						2'h2:
							if (bitCnt_q < 4'h8)
								rxShift_q <= {rxShift_q[6:0], sdaSync_q[1]};
							else if (sending && sdaSync_q[1])
								nack_q <= 1'b1;
						default:
						begin
							scl_q <= 1'b0;
							if (bitCnt_q == 4'h8)
							begin
								if (!sending)
									rx_q <= {rxShift_q, rx_q[23:8]};
								bitCnt_q <= 4'h0;
								byteIdx_q <= byteIdx_q + 2'h1;
								if (nack_q || lastByte)
									state_q <= HS_STOP;
							end
							else
								bitCnt_q <= bitCnt_q + 4'h1;
						end
					endcase
				HS_STOP:
					case (phase_q)
						2'h0: sdaOe_q <= 1'b1;
						2'h1: scl_q <= 1'b1;
						2'h2: sdaOe_q <= 1'b0;
						default: state_q <= HS_IDLE;
					endcase
				default:
					state_q <= HS_IDLE;
			endcase
		end

	// events: transfer done, device interrupt line fell; set wins over read clear
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			evt_q <= 2'h0;
			mask_q <= 2'h0;
			strap_q <= 3'h0;
		end
		else
		begin
			evt_q <= (rdEvt ? 2'h0 : evt_q) | {intPrev_q & ~intSync_q[1], done};
			if (wrStb && addr == HOST_MASK)
				mask_q <= wrData[1:0];
			if (wrStb && addr == HOST_ADDR)
				strap_q <= wrData[2:0];
		end

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			rdData <= 32'h00000000;
		else if (rdStb)
			case (addr)
				HOST_ADDR: rdData <= {29'h0, strap_q};
				HOST_STAT: rdData <= {29'h0, ~intSync_q[1], nack_q, state_q != HS_IDLE};
				HOST_RXD:  rdData <= {8'h00, rx_q};
				HOST_EVT:  rdData <= {30'h0, evt_q};
				HOST_MASK: rdData <= {30'h0, mask_q};
				default:   rdData <= 32'h00000000;
			endcase
		else
			rdData <= 32'h00000000;
endmodule

/* rtl/rap_dev.sv */
`timescale 1ns/1ps
// Behaviour
// - stop output when reflected exceeds half forward
// - overheat stops both channels, cuts supply
// - supply fault stops the amplifiers
// - gate lines per amplifier, third ignored
// - error lamp on any fault, inhibits emission
// - pulse lamp per channel when power present
// - normal mode: stop, flag, no interrupt
// - interrupt mode: also pull interrupt low
// - interrupt mode latches faults until clear
// - address 0100 plus three strap bits
// - bit two summary fault, active low
// - bits three to five, active-low faults
// - bit six low enables interrupt, reset one
// - bit seven clears fault flags
// - router select decodes four routings
// - one forward power byte per amplifier
// - power sampled and held for reading
// - 32 kbyte linearization store
module rap_dev
	import rap_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// link
	rap_link_if.dev                link,
	// straps and sensors
	input  wire logic [2:0]        addrStrap,
	input  wire logic              overheat,
	input  wire logic              supplyLoss,
	input  wire logic [7:0]        fwdPwrOne,
	input  wire logic [7:0]        reflPwrOne,
	input  wire logic [7:0]        fwdPwrTwo,
	input  wire logic [7:0]        reflPwrTwo,
	// blanking gates, high allows emission
	input  wire logic              gateLineAmpOne,
	input  wire logic              gateLineAmpTwo,
	input  wire logic              gateLineUnused,
	// amplifier and panel control
	output logic                   ampOneEnable,
	output logic                   ampTwoEnable,
	output logic                   ampSupplyEnable,
	output logic                   errorLed,
	output logic                   pulseLedOne,
	output logic                   pulseLedTwo,
	output logic                   overheatFaultN,
	output logic                   supplyLossFaultN,
	// router
	output logic                   routeSelectLow,
	output logic                   routeSelectHigh,
	output logic [3:0]             routeSwitch,
	// linearization store
	input  wire logic [LIN_AW-1:0] linAddr,
	input  wire logic [7:0]        linWrData,
	input  wire logic              linWe,
	output logic      [7:0]        linRdData
);
	logic [40:0] sync1_q, sync2_q;
	logic [1:0]  linkPrev_q;
	logic        scl, sda, sclRise, sclFall, startCond, stopCond;
	logic [2:0]  strap;
	logic        hot, noSupply, gateOne, gateTwo;
	logic [7:0]  fwdOne, reflOne, fwdTwo, reflTwo;
	rap_dev_state_t state_q;
	logic [3:0]  cnt_q;
	logic [7:0]  shift_q, tx_q;
	logic [1:0]  rdIdx_q, route_q;
	logic        mAck_q, sdaOe_q, regWr_q;
	logic [15:0] pwrHold_q;
	logic        intDis_q, thFlag_q, spFlag_q, mmFlag_q;
	logic        mismOne, mismTwo, anyFault, clr, latch;
	logic [7:0]  statusByte, txNext;
	logic [7:0]  linMem [LIN_DEPTH];

	// straps, sensors, the two amplifier gates and the link pass two flops before use
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			sync1_q <= 41'h00000000003;
			sync2_q <= 41'h00000000003;
			linkPrev_q <= 2'h3;
		end
		else
		begin
			sync1_q <= {addrStrap, overheat, supplyLoss, gateLineAmpOne, gateLineAmpTwo,
				fwdPwrOne, reflPwrOne, fwdPwrTwo, reflPwrTwo, link.scl, link.sda};
			sync2_q <= sync1_q;
			linkPrev_q <= sync2_q[1:0];
		end

	assign {strap, hot, noSupply, gateOne, gateTwo, fwdOne, reflOne, fwdTwo, reflTwo, scl, sda}
		= sync2_q;
	assign sclRise = scl & ~linkPrev_q[1];
	assign sclFall = ~scl & linkPrev_q[1];
	assign startCond = scl & linkPrev_q[1] & linkPrev_q[0] & ~sda;
	assign stopCond = scl & linkPrev_q[1] & ~linkPrev_q[0] & sda;
	assign mismOne = {1'b0, reflOne, 1'b0} > {2'b00, fwdOne};
	assign mismTwo = {1'b0, reflTwo, 1'b0} > {2'b00, fwdTwo};
	assign anyFault = thFlag_q | spFlag_q | mmFlag_q;
	assign clr = regWr_q & shift_q[ST_CLEAR];
	assign latch = ~intDis_q;
	assign statusByte = {1'b1, intDis_q, ~mmFlag_q, ~spFlag_q, ~thFlag_q, ~anyFault, route_q};
	assign txNext = (rdIdx_q == 2'h0) ? statusByte
		: (rdIdx_q == 2'h1) ? pwrHold_q[7:0] : pwrHold_q[15:8];
	assign link.devSdaOut = 1'b0;
	assign link.devSdaOe = sdaOe_q;
	assign link.devIntOut = 1'b0;
	// slave sequencer
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			state_q <= DS_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			rdIdx_q <= 2'h0;
			mAck_q <= 1'b0;
			sdaOe_q <= 1'b0;
			regWr_q <= 1'b0;
			pwrHold_q <= 16'h0000;
		end
		else
		begin
			regWr_q <= 1'b0;
			if (startCond)
			begin
				state_q <= DS_ADDR;
				cnt_q <= 4'h0;
				sdaOe_q <= 1'b0;
			end
			else if (stopCond)
			begin
				state_q <= DS_IDLE;
				sdaOe_q <= 1'b0;
			end
			else if (sclRise)
				case (state_q)
					DS_ADDR, DS_WDATA:
					begin
						shift_q <= {shift_q[6:0], sda};
						cnt_q <= cnt_q + 4'h1;
					end
					DS_RDATA: cnt_q <= cnt_q + 4'h1;
					DS_RACK: mAck_q <= ~sda;
					default: cnt_q <= cnt_q;
				endcase
			else if (sclFall)
				case (state_q)
					DS_ADDR:
						if (cnt_q == 4'h8)
						begin
							if (shift_q[7:1] == {DEV_ADDR_HI, strap})
							begin
								state_q <= DS_AACK;
								sdaOe_q <= 1'b1;
								rdIdx_q <= 2'h0;
								pwrHold_q <= {fwdTwo, fwdOne};
							end
							else
								state_q <= DS_IDLE;
						end
					DS_AACK, DS_WACK:
					begin
						cnt_q <= 4'h0;
						if (state_q == DS_AACK && shift_q[0])
						begin
							state_q <= DS_RDATA;
							tx_q <= txNext;
							sdaOe_q <= ~txNext[7];
						end
						else
						begin
							state_q <= DS_WDATA;
							sdaOe_q <= 1'b0;
						end
					end
					DS_WDATA:
						if (cnt_q == 4'h8)
						begin
							state_q <= DS_WACK;
							sdaOe_q <= 1'b1;
							regWr_q <= 1'b1;
						end
					DS_RDATA:
						if (cnt_q == 4'h8)
						begin
							state_q <= DS_RACK;
							sdaOe_q <= 1'b0;
							rdIdx_q <= (rdIdx_q == RD_LAST_IDX) ? 2'h0 : rdIdx_q + 2'h1;
						end
						else
							sdaOe_q <= ~tx_q[3'(4'h7 - cnt_q)];
					DS_RACK:
						if (mAck_q)
						begin
							state_q <= DS_RDATA;
							cnt_q <= 4'h0;
							tx_q <= txNext;
							sdaOe_q <= ~txNext[7];
						end
						else
							state_q <= DS_IDLE;
					default:
						sdaOe_q <= 1'b0;
				endcase
		end
	// control fields and fault flags; a live fault wins over a clear
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			route_q <= ROUTE_RST;
			intDis_q <= INT_DIS_RST;
			thFlag_q <= 1'b0;
			spFlag_q <= 1'b0;
			mmFlag_q <= 1'b0;
		end
		else
		begin
			if (regWr_q)
			begin
				route_q <= shift_q[ST_ROUTE_HI:ST_ROUTE_LO];
				intDis_q <= shift_q[ST_INT_DIS];
			end
			thFlag_q <= hot | (latch & thFlag_q & ~clr);
			spFlag_q <= noSupply | (latch & spFlag_q & ~clr);
			mmFlag_q <= mismOne | mismTwo | (latch & mmFlag_q & ~clr);
		end
	// outputs, any live or held fault blanks both amplifiers
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			ampOneEnable <= 1'b0;
			ampTwoEnable <= 1'b0;
			ampSupplyEnable <= 1'b0;
			errorLed <= 1'b0;
			pulseLedOne <= 1'b0;
			pulseLedTwo <= 1'b0;
			overheatFaultN <= 1'b1;
			supplyLossFaultN <= 1'b1;
			link.devIntOe <= 1'b0;
			routeSelectLow <= ROUTE_RST[0];
			routeSelectHigh <= ROUTE_RST[1];
			routeSwitch <= {ROUTE_RST[0], ROUTE_RST[1], ~ROUTE_RST[0], ~ROUTE_RST[1]};
		end
		else
		begin
			ampOneEnable <= gateOne & ~anyFault & ~mismOne;
			ampTwoEnable <= gateTwo & ~anyFault & ~mismTwo;
			ampSupplyEnable <= ~thFlag_q;
			errorLed <= anyFault;
			pulseLedOne <= fwdOne != 8'h00;
			pulseLedTwo <= fwdTwo != 8'h00;
			overheatFaultN <= ~thFlag_q;
			supplyLossFaultN <= ~spFlag_q;
			link.devIntOe <= ~intDis_q & anyFault;
			routeSelectLow <= route_q[0];
			routeSelectHigh <= route_q[1];
			// in1-rf_output_one, in2-rf_output_two, in1-rf_output_two, in2-rf_output_one
			routeSwitch <= {route_q[0], route_q[1], ~route_q[0], ~route_q[1]};
		end
	// linearization store
	always_ff @(posedge core_clk)
	begin
		if (linWe)
			linMem[linAddr] <= linWrData;
		linRdData <= linMem[linAddr];
	end
endmodule

/* verification/rap_link_monitor.sv */
`timescale 1ns/1ps
module rap_link_monitor
(
	// clock and reset
	input wire logic       core_clk,
	input wire logic       nrst,
	// link
	input wire logic       scl,
	input wire logic       devSdaOe,
	input wire logic       statusIntN,
	// sensors and gates
	input wire logic       overheat,
	input wire logic       supplyLoss,
	input wire logic [7:0] fwdPwrOne,
	input wire logic [7:0] reflPwrOne,
	input wire logic       gateLineAmpOne,
	// amplifier and panel
	input wire logic       ampOneEnable,
	input wire logic       ampTwoEnable,
	input wire logic       ampSupplyEnable,
	input wire logic       errorLed,
	input wire logic       pulseLedOne,
	input wire logic       overheatFaultN,
	input wire logic       supplyLossFaultN,
	input wire logic       routeSelectLow,
	input wire logic       routeSelectHigh,
	input wire logic [3:0] routeSwitch
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// two sync flops, then the output flop: four cycles; a fault flag adds one more
	property p_heat_stop;
		overheat [*5] |-> !ampOneEnable && !ampTwoEnable && !ampSupplyEnable;
	endproperty
	a_heat_stop: assert property (p_heat_stop)
		else $error("overheat left emission or supply on");
	property p_heat_flag;
		overheat [*5] |-> !overheatFaultN && errorLed;
	endproperty
	a_heat_flag: assert property (p_heat_flag)
		else $error("overheat flag or lamp missing");
	property p_supply_stop;
		supplyLoss [*5] |-> !ampOneEnable && !ampTwoEnable && !supplyLossFaultN;
	endproperty
	a_supply_stop: assert property (p_supply_stop)
		else $error("supply loss left emission on");
	property p_mism_one;
		({reflPwrOne, 1'h0} > {1'h0, fwdPwrOne}) [*4] |-> !ampOneEnable;
	endproperty
	a_mism_one: assert property (p_mism_one)
		else $error("mismatch on channel one left emission on");
	property p_gate_one;
		!gateLineAmpOne [*4] |-> !ampOneEnable;
	endproperty
	a_gate_one: assert property (p_gate_one)
		else $error("blank line one did not stop amplifier one");
	property p_err_inhibit;
		errorLed |-> !ampOneEnable && !ampTwoEnable;
	endproperty
	a_err_inhibit: assert property (p_err_inhibit)
		else $error("emission enabled while error lamp lit");
	property p_pulse_one;
		(fwdPwrOne != 8'h00) [*4] |-> pulseLedOne;
	endproperty
	a_pulse_one: assert property (p_pulse_one)
		else $error("pulse lamp one dark with power present");
	property p_route;
		$stable({routeSelectHigh, routeSelectLow}) |->
			routeSwitch == {routeSelectLow, routeSelectHigh, !routeSelectLow, !routeSelectHigh};
	endproperty
	a_route: assert property (p_route)
		else $error("router switches disagree with select bits");
	property p_sda_hold;
		scl && $past(scl) |-> $stable(devSdaOe);
	endproperty
	a_sda_hold: assert property (p_sda_hold)
		else $error("device moved data line while clock high");

	c_heat: cover property (overheat && !ampSupplyEnable);
	c_int: cover property ($fell(statusIntN));
	c_swap: cover property (routeSwitch == 4'h3);
endmodule

/* verification/test_rap.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		nChecks++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("Error %s expected %h seen %h", nm, e, g); \
		end \
	end
module test_rap
	import rap_pkg::*;
;
	logic              core_clk       = 1'h0;
	logic              nrst           = 1'h0;
	logic [7:0]        addr           = 8'h00;
	logic [31:0]       wrData         = 32'h0;
	logic              wrStb          = 1'h0;
	logic              rdStb          = 1'h0;
	logic [2:0]        addrStrap      = 3'h5;
	logic              overheat       = 1'h0;
	logic              supplyLoss     = 1'h0;
	logic [7:0]        fwdPwrOne      = 8'h5a;
	logic [7:0]        reflPwrOne     = 8'h00;
	logic [7:0]        fwdPwrTwo      = 8'hc3;
	logic [7:0]        reflPwrTwo     = 8'h00;
	logic              gateLineAmpOne = 1'h1;
	logic              gateLineAmpTwo = 1'h1;
	logic              gateLineUnused = 1'h0;
	logic [LIN_AW-1:0] linAddr        = 15'h0;
	logic [7:0]        linWrData      = 8'h00;
	logic              linWe          = 1'h0;
	logic [31:0]       rdData;
	logic              irq;
	logic              ampOneEnable, ampTwoEnable, ampSupplyEnable, errorLed;
	logic              pulseLedOne, pulseLedTwo, overheatFaultN, supplyLossFaultN;
	logic              routeSelectLow, routeSelectHigh;
	logic [3:0]        routeSwitch;
	logic [7:0]        linRdData;
	logic [31:0]       v;
	int                miscompares    = 0;
	int                nChecks        = 0;
	int                cycles         = 0;

	rap_link_if link ();
	rap_host u_rap_host (.*);
	rap_dev u_rap_dev (.*);
	rap_link_monitor u_rap_link_monitor (
		.*,
		.scl        (link.scl),
		.devSdaOe   (link.devSdaOe),
		.statusIntN (link.statusIntN)
	);

	always #4 core_clk = ~core_clk;

	task automatic close_out;
		$display("checks %0d mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 50000)
		begin
			miscompares++;
			close_out();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'h1;
		@(posedge core_clk);
		wrStb <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		rdStb <= 1'h1;
		@(posedge core_clk);
		rdStb <= 1'h0;
		#1 d = rdData;
	endtask

	// one link transfer, status left in v
	task automatic xfer(input logic [2:0] sa, input logic [8:0] cmd);
		int i;
		wr(HOST_ADDR, {29'h0, sa});
		wr(HOST_CMD, {23'h0, cmd});
		v = 32'h1;
		for (i = 0; i < 40000 && v[0] !== 1'h0; i++)
			rd(HOST_STAT, v);
	endtask

	task automatic settle;
		repeat (6) @(posedge core_clk);
		#1;
	endtask

	initial
	begin
		repeat (4) @(posedge core_clk);
		nrst <= 1'h1;
		settle();
		`CHK("enables", 3'h7, {ampOneEnable, ampTwoEnable, ampSupplyEnable})
		`CHK("pulse lamps", 2'h3, {pulseLedOne, pulseLedTwo})
		`CHK("route reset", 4'hc, routeSwitch)
		wr(HOST_MASK, 32'h3);
		rd(HOST_MASK, v);
		`CHK("mask", 32'h3, v)
		rd(8'h18, v);
		`CHK("unmapped", 32'h0, v)
		// linearization store, both ends of the range
		@(posedge core_clk);
		linAddr <= 15'h7fff;
		linWrData <= 8'ha5;
		linWe <= 1'h1;
		@(posedge core_clk);
		linAddr <= 15'h0;
		linWrData <= 8'h3c;
		@(posedge core_clk);
		linWe <= 1'h0;
		linAddr <= 15'h7fff;
		@(posedge core_clk);
		#1 `CHK("store top", 8'ha5, linRdData)
		@(posedge core_clk);
		linAddr <= 15'h0;
		@(posedge core_clk);
		#1 `CHK("store base", 8'h3c, linRdData)
		// blank one amplifier, unused line toggled
		@(posedge core_clk);
		gateLineAmpOne <= 1'h0;
		gateLineUnused <= 1'h1;
		settle();
		`CHK("blank one", 2'h1, {ampOneEnable, ampTwoEnable})
		@(posedge core_clk);
		gateLineAmpOne <= 1'h1;
		settle();
		`CHK("unused ignored", 2'h3, {ampOneEnable, ampTwoEnable})
		// wrong strap value is refused
		xfer(3'h2, 9'h000);
		`CHK("nack", 1'h1, v[1])
		`CHK("route kept", 4'hc, routeSwitch)
		// swapped routing, interrupt mode
		xfer(3'h5, 9'h000);
		`CHK("ack", 1'h0, v[1])
		`CHK("select bits", 2'h0, {routeSelectHigh, routeSelectLow})
		`CHK("swap", 4'h3, routeSwitch)
		`CHK("int idle", 1'h1, link.statusIntN)
		@(posedge core_clk);
		overheat <= 1'h1;
		settle();
		`CHK("heat stop", 3'h0, {ampOneEnable, ampTwoEnable, ampSupplyEnable})
		`CHK("error lamp", 1'h1, errorLed)
		`CHK("int low", 1'h0, link.statusIntN)
		@(posedge core_clk);
		overheat <= 1'h0;
		settle();
		`CHK("int latched", 1'h0, link.statusIntN)
		`CHK("heat latched", 1'h0, overheatFaultN)
		xfer(3'h5, 9'h100);
		rd(HOST_RXD, v);
		`CHK("status and power", 24'hc35ab0, v[23:0])
		`CHK("irq up", 1'h1, irq)
		rd(HOST_EVT, v);
		`CHK("events", 32'h3, v)
		`CHK("irq down", 1'h0, irq)
		// clear in interrupt mode, straight routing
		xfer(3'h5, 9'h083);
		settle();
		`CHK("int released", 1'h1, link.statusIntN)
		`CHK("heat cleared", 1'h1, overheatFaultN)
		`CHK("resumed", 3'h7, {ampOneEnable, ampTwoEnable, ampSupplyEnable})
		`CHK("straight", 4'hc, routeSwitch)
		// normal mode from here on
		xfer(3'h5, 9'h0c3);
		@(posedge core_clk);
		reflPwrOne <= 8'h2d;
		reflPwrTwo <= 8'h61;
		settle();
		`CHK("below half", 2'h3, {ampOneEnable, ampTwoEnable})
		@(posedge core_clk);
		reflPwrOne <= 8'h2e;
		reflPwrTwo <= 8'h62;
		settle();
		`CHK("above half", 2'h0, {ampOneEnable, ampTwoEnable})
		`CHK("mism lamp", 1'h1, errorLed)
		`CHK("no int", 1'h1, link.statusIntN)
		@(posedge core_clk);
		reflPwrOne <= 8'h00;
		reflPwrTwo <= 8'h00;
		supplyLoss <= 1'h1;
		settle();
		`CHK("supply stop", 3'h0, {ampOneEnable, ampTwoEnable, supplyLossFaultN})
		close_out();
	end
endmodule
